// File: hdl/wdw_pkg.sv
package wdw_pkg;

    // Register byte offsets
    localparam logic [11:0] OFF_RELOAD_KEY     = 12'h000;
    localparam logic [11:0] OFF_WINDOW_CONTROL = 12'h004;
    localparam logic [11:0] OFF_WINDOW_FLAGS   = 12'h008;
    localparam logic [11:0] OFF_COUNT_VALUE    = 12'h00C;
    localparam logic [11:0] OFF_IRQ_ENABLE     = 12'h010;
    localparam logic [11:0] OFF_IRQ_CLEAR      = 12'h014;

    // Control field positions
    localparam int CTL_RUN_EN_BIT     = 0;
    localparam int CTL_IRQ_EN_BIT     = 1;
    localparam int CTL_PSC_LSB        = 8;
    localparam int CTL_PSC_MSB        = 11;
    localparam int CTL_CMP_LSB        = 16;
    localparam int CTL_CMP_MSB        = 21;
    localparam int CTL_DBG_DIS_BIT    = 31;

    // Flag positions
    localparam int FLAG_MATCH_BIT     = 0;
    localparam int FLAG_TIMEOUT_BIT   = 1;

    // Values after reset
    localparam logic [31:0] RST_WINDOW_CONTROL = 32'h003F0800;
    localparam logic [5:0]  RST_CMP            = 6'h3F;
    localparam logic [3:0]  RST_PSC            = 4'h8;
    localparam logic [1:0]  RST_IRQ_ENABLE     = 2'h3;

    // Counter and key
    localparam logic [31:0] RELOAD_KEY_VALUE   = 32'h00005AA5;
    localparam logic [5:0]  CNT_FULL           = 6'h3F;
    localparam logic [5:0]  CNT_ZERO           = 6'h00;

    // Clocking
    localparam int          CLK_SYS_HZ         = 250_000_000;
    localparam int          LOW_SPEED_OSC_HZ   = 38_400;
    localparam int          SYS_TICK_DIV       = 2048;
    localparam logic [10:0] SYS_TICK_LAST      = 11'(SYS_TICK_DIV - 1);
    localparam logic [1:0]  RELOAD_SYNC_TICKS  = 2'h3;

    // Run state, Gray coded
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_RUN     = 2'b01,
        ST_TRIPPED = 2'b11
    } wdw_state_e;

endpackage : wdw_pkg

// File: hdl/wdw_window_watchdog.sv
// Contract
// - Setting the run enable starts the 6-bit counter at 0x3F and decrements it on each prescaled tick.
// - Only the first write to the control register after reset takes effect.
// - The tick comes from the system clock divided by 2048 or the low-speed oscillator, then a prescaler.
// - Prescale codes 0 to 15 divide by 1,2,4,8,16,32,64,128,192,256,384,512,768,1024,1536,2048.
// - The counter pauses while the CPU is idle or powered down and resumes afterwards.
// - The match flag in bit 0 sets when the counter equals a compare value other than 0x3F or 0x0 while counting.
// - The match interrupt is raised while the match flag is set and the interrupt enable is 1.
// - A reload key written while the counter is above the compare value resets the system at once.
// - A reload key written while the counter is at or below the compare value reloads 0x3F.
// - Reaching zero without a reload resets the system and sets the time-out flag.
// - A reload takes effect three watchdog clock ticks after the key write.
// - Compare values 0x3F and 0x0 never raise the match interrupt.
// - With the debug hold disable at 0 the counter freezes during a debug halt, else it keeps running.
// - A flag clears only when software writes 1 to its bit.
// - The count value register shows the live counter in bits 5 to 0.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module wdw_window_watchdog (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Clock source
    input  wire logic        lowSpeedOsc,
    input  wire logic        tickSrcSelect,
    // CPU state
    input  wire logic        cpuSleep,
    input  wire logic        debugHalt,
    // Outputs to system
    output logic             matchIrq,
    output logic             irq,
    output logic             sysResetReq
);

    logic [5:0]  downCountValue_q;
    logic [5:0]  windowCompareValue_q;
    logic [3:0]  prescaleSelect_q;
    logic        watchdogRunEnable_q;
    logic        matchIrqEnable_q;
    logic        debugHoldDisable_q;
    logic        ctlLocked_q;
    logic        compareMatchFlag_q;
    logic        timeoutResetFlag_q;
    logic [1:0]  irqEnable_q;
    logic        sysResetReq_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    wdw_pkg::wdw_state_e state_q;

    logic [10:0] sysDiv_q;
    logic [2:0]  oscSync_q;
    logic        oscLevel_q;
    logic [10:0] presc_q;
    logic        reloadPending_q;
    logic [1:0]  reloadSync_q;

    // Prescale code to division value
    function automatic logic [11:0] psc_divide(input logic [3:0] code);
        case (code)
            4'h0:    psc_divide = 12'h001;
            4'h1:    psc_divide = 12'h002;
            4'h2:    psc_divide = 12'h004;
            4'h3:    psc_divide = 12'h008;
            4'h4:    psc_divide = 12'h010;
            4'h5:    psc_divide = 12'h020;
            4'h6:    psc_divide = 12'h040;
            4'h7:    psc_divide = 12'h080;
            4'h8:    psc_divide = 12'h0C0;
            4'h9:    psc_divide = 12'h100;
            4'hA:    psc_divide = 12'h180;
            4'hB:    psc_divide = 12'h200;
            4'hC:    psc_divide = 12'h300;
            4'hD:    psc_divide = 12'h400;
            4'hE:    psc_divide = 12'h600;
            default: psc_divide = 12'h800;
        endcase
    endfunction : psc_divide

    // Bus decode
    logic        setupPh;
    logic        wrAccess;
    logic        addrMapped;
    logic        keyWrite;
    logic        keyValid;
    logic        ctlWrite;
    logic        flagsWrite;
    logic        clrWrite;
    logic        ienWrite;

    assign setupPh    = psel & ~penable;
    assign wrAccess   = psel & penable & pwrite;
    assign addrMapped = (paddr == wdw_pkg::OFF_RELOAD_KEY)     |
                        (paddr == wdw_pkg::OFF_WINDOW_CONTROL) |
                        (paddr == wdw_pkg::OFF_WINDOW_FLAGS)   |
                        (paddr == wdw_pkg::OFF_COUNT_VALUE)    |
                        (paddr == wdw_pkg::OFF_IRQ_ENABLE)     |
                        (paddr == wdw_pkg::OFF_IRQ_CLEAR);
    assign keyWrite   = wrAccess & (paddr == wdw_pkg::OFF_RELOAD_KEY);
    assign keyValid   = keyWrite & (pwdata == wdw_pkg::RELOAD_KEY_VALUE);
    assign ctlWrite   = wrAccess & (paddr == wdw_pkg::OFF_WINDOW_CONTROL);
    assign flagsWrite = wrAccess & (paddr == wdw_pkg::OFF_WINDOW_FLAGS);
    assign clrWrite   = wrAccess & (paddr == wdw_pkg::OFF_IRQ_CLEAR);
    assign ienWrite   = wrAccess & (paddr == wdw_pkg::OFF_IRQ_ENABLE);

    // Tick sources
    logic sysTick;
    logic oscTick;
    logic wdTick;
    logic countOn;
    logic countTick;
    logic [11:0] divValue;
    logic [5:0]  cntNext;

    assign sysTick = (sysDiv_q == wdw_pkg::SYS_TICK_LAST);
    assign oscTick = (oscSync_q[2] == oscSync_q[1]) & oscSync_q[1] & ~oscLevel_q;
    assign wdTick  = tickSrcSelect ? oscTick : sysTick;

    assign countOn = (state_q == wdw_pkg::ST_RUN) & ~cpuSleep
                   & ~(debugHalt & ~debugHoldDisable_q);
    assign divValue  = psc_divide(prescaleSelect_q);
    assign countTick = countOn & wdTick & ({1'b0, presc_q} == divValue - 12'h001);
    assign cntNext   = downCountValue_q - 6'h01;

    logic reloadNow;
    logic hitZero;
    logic hitMatch;
    logic earlyKey;

    assign reloadNow = reloadPending_q & wdTick & (reloadSync_q == wdw_pkg::RELOAD_SYNC_TICKS - 2'h1);
    assign hitZero   = countTick & (cntNext == wdw_pkg::CNT_ZERO);
    assign hitMatch  = countTick & (cntNext == windowCompareValue_q)
                     & (windowCompareValue_q != wdw_pkg::CNT_FULL)
                     & (windowCompareValue_q != wdw_pkg::CNT_ZERO);
    assign earlyKey  = keyValid & (state_q == wdw_pkg::ST_RUN)
                     & (downCountValue_q > windowCompareValue_q);

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sysDiv_q <= 11'h000;
        end else begin
            sysDiv_q <= sysDiv_q + 11'h001;
        end
    end

    // Low-speed oscillator arrives from its own domain
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            oscSync_q  <= 3'h0;
            oscLevel_q <= 1'b0;
        end else begin
            oscSync_q <= {oscSync_q[1:0], lowSpeedOsc};
            if (oscSync_q[2] == oscSync_q[1]) begin
                oscLevel_q <= oscSync_q[1];
            end
        end
    end

    // Control register, written once
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ctlLocked_q          <= 1'b0;
            watchdogRunEnable_q  <= 1'b0;
            matchIrqEnable_q     <= 1'b0;
            prescaleSelect_q     <= wdw_pkg::RST_PSC;
            windowCompareValue_q <= wdw_pkg::RST_CMP;
            debugHoldDisable_q   <= 1'b0;
        end else if (ctlWrite && !ctlLocked_q) begin
            ctlLocked_q          <= 1'b1;
            watchdogRunEnable_q  <= pwdata[wdw_pkg::CTL_RUN_EN_BIT];
            matchIrqEnable_q     <= pwdata[wdw_pkg::CTL_IRQ_EN_BIT];
            prescaleSelect_q     <= pwdata[wdw_pkg::CTL_PSC_MSB:wdw_pkg::CTL_PSC_LSB];
            windowCompareValue_q <= pwdata[wdw_pkg::CTL_CMP_MSB:wdw_pkg::CTL_CMP_LSB];
            debugHoldDisable_q   <= pwdata[wdw_pkg::CTL_DBG_DIS_BIT];
        end
    end

    // Run state
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_q <= wdw_pkg::ST_IDLE;
        end else begin
            case (state_q)
                wdw_pkg::ST_IDLE: begin
                    if (watchdogRunEnable_q) begin
                        state_q <= wdw_pkg::ST_RUN;
                    end
                end
                wdw_pkg::ST_RUN: begin
                    if (hitZero || earlyKey) begin
                        state_q <= wdw_pkg::ST_TRIPPED;
                    end
                end
                wdw_pkg::ST_TRIPPED: begin
                    state_q <= wdw_pkg::ST_TRIPPED;
                end
                default: begin
                    state_q <= wdw_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Prescaler restarts with every reload so the next period is full
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            presc_q <= 11'h000;
        end else if (reloadNow || state_q != wdw_pkg::ST_RUN) begin
            presc_q <= 11'h000;
        end else if (countTick) begin
            presc_q <= 11'h000;
        end else if (countOn && wdTick) begin
            presc_q <= presc_q + 11'h001;
        end
    end

    // Down counter; a zero on the same tick as the reload wins
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            downCountValue_q <= wdw_pkg::CNT_FULL;
        end else if (state_q == wdw_pkg::ST_RUN) begin
            if (reloadNow && !hitZero) begin
                downCountValue_q <= wdw_pkg::CNT_FULL;
            end else if (countTick) begin
                downCountValue_q <= cntNext;
            end
        end
    end

    // Reload command crosses into the watchdog tick domain
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            reloadPending_q <= 1'b0;
            reloadSync_q    <= 2'h0;
        end else if (reloadNow || state_q != wdw_pkg::ST_RUN) begin
            reloadPending_q <= 1'b0;
            reloadSync_q    <= 2'h0;
        end else if (reloadPending_q) begin
            if (wdTick) begin
                reloadSync_q <= reloadSync_q + 2'h1;
            end
        end else if (keyValid && !earlyKey) begin
            reloadPending_q <= 1'b1;
            reloadSync_q    <= 2'h0;
        end
    end

    // Flags: hardware set wins over a software clear
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            compareMatchFlag_q <= 1'b0;
            timeoutResetFlag_q <= 1'b0;
        end else begin
            if (hitMatch) begin
                compareMatchFlag_q <= 1'b1;
            end else if ((flagsWrite || clrWrite) && pwdata[wdw_pkg::FLAG_MATCH_BIT]) begin
                compareMatchFlag_q <= 1'b0;
            end
            if (hitZero) begin
                timeoutResetFlag_q <= 1'b1;
            end else if ((flagsWrite || clrWrite) && pwdata[wdw_pkg::FLAG_TIMEOUT_BIT]) begin
                timeoutResetFlag_q <= 1'b0;
            end
        end
    end

    // System reset request holds until the chip reset arrives
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sysResetReq_q <= 1'b0;
        end else if (hitZero || earlyKey) begin
            sysResetReq_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            irqEnable_q <= wdw_pkg::RST_IRQ_ENABLE;
        end else if (ienWrite) begin
            irqEnable_q <= pwdata[1:0];
        end
    end

    // Read data captured in the setup phase
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (setupPh) begin
            pslverr_q <= ~addrMapped;
            prdata_q  <= 32'h00000000;
            if (!pwrite) begin
                case (paddr)
                    wdw_pkg::OFF_WINDOW_CONTROL: begin
                        prdata_q <= {debugHoldDisable_q, 9'h000, windowCompareValue_q,
                                     4'h0, prescaleSelect_q, 6'h00,
                                     matchIrqEnable_q, watchdogRunEnable_q};
                    end
                    wdw_pkg::OFF_WINDOW_FLAGS: begin
                        prdata_q <= {30'h00000000, timeoutResetFlag_q, compareMatchFlag_q};
                    end
                    wdw_pkg::OFF_COUNT_VALUE: begin
                        prdata_q <= {26'h0000000, downCountValue_q};
                    end
                    wdw_pkg::OFF_IRQ_ENABLE: begin
                        prdata_q <= {30'h00000000, irqEnable_q};
                    end
                    default: begin
                        prdata_q <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    assign prdata      = prdata_q;
    assign pready      = 1'b1;
    assign pslverr     = pslverr_q & psel & penable;
    assign matchIrq    = compareMatchFlag_q & matchIrqEnable_q;
    assign irq         = (compareMatchFlag_q & matchIrqEnable_q & irqEnable_q[0])
                       | (timeoutResetFlag_q & irqEnable_q[1]);
    assign sysResetReq = sysResetReq_q;

endmodule : wdw_window_watchdog

// File: dv/wdw_window_watchdog_sva.sv
`timescale 1ns/1ps
module wdw_window_watchdog_sva (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        resetn,
    // APB
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // CPU state and outputs
    input wire logic        cpuSleep,
    input wire logic        matchIrq,
    input wire logic        irq,
    input wire logic        sysResetReq
);
    logic acc;
    logic mapped;
    assign acc = psel && penable;
    assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    ready_now_a: assert property (acc |-> pready) else $error("pready low in access");
    bad_addr_a: assert property (acc && !mapped |-> pslverr) else $error("no slave error");
    no_err_a: assert property (!acc || mapped |-> !pslverr) else $error("spurious slave error");
    read_hold_a: assert property ($past(acc) && !psel |-> $stable(prdata))
        else $error("read data moved");
    key_read_a: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata == 32'h0)
        else $error("write-only register read nonzero");
    count_read_a: assert property (acc && !pwrite && paddr == 12'h00C |-> prdata[31:6] == 26'h0)
        else $error("count reserved bits set");
    reset_hold_a: assert property (sysResetReq |=> sysResetReq) else $error("reset dropped");
    wrong_key_a: assert property (acc && pwrite && paddr == 12'h000
        && pwdata != wdw_pkg::RELOAD_KEY_VALUE && !sysResetReq |=> !sysResetReq)
        else $error("reset on wrong key");
    clean_start_a: assert property ($rose(resetn) |-> !sysResetReq && !irq && !matchIrq)
        else $error("outputs set after reset");
    sleep_still_a: assert property (cpuSleep && $past(cpuSleep) && $past(cpuSleep, 2)
        && !$past(acc) |-> !$rose(matchIrq)) else $error("match while asleep");
endmodule : wdw_window_watchdog_sva

bind wdw_window_watchdog wdw_window_watchdog_sva u_sva (
    .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpuSleep(cpuSleep), .matchIrq(matchIrq), .irq(irq), .sysResetReq(sysResetReq)
);

// File: dv/wdw_window_watchdog_test.sv
`timescale 1ns/1ps
module wdw_window_watchdog_test;
    logic        clk_sys;
    logic        resetn;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        lowSpeedOsc;
    logic        tickSrcSelect;
    logic        cpuSleep;
    logic        debugHalt;
    logic        matchIrq;
    logic        irq;
    logic        sysResetReq;
    int          err_total;
    int          check_count;
    int          cycles;
    int          n;
    logic [31:0] rd;
    logic [31:0] held;
    logic        se;

    wdw_window_watchdog u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lowSpeedOsc(lowSpeedOsc), .tickSrcSelect(tickSrcSelect), .cpuSleep(cpuSleep),
        .debugHalt(debugHalt), .matchIrq(matchIrq), .irq(irq), .sysResetReq(sysResetReq)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Fast stand-in for the oscillator: one tick every 64 clocks
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        lowSpeedOsc <= cycles[5];
        if (cycles == 60000) begin
            err_total = err_total + 1;
            test_done();
        end
    end

    task automatic test_done();
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        @(posedge clk_sys);
        while (pready !== 1'b1 && k < 16) begin
            @(posedge clk_sys);
            k++;
        end
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask : rdchk

    task automatic do_reset();
        resetn <= 1'b0;
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
    endtask : do_reset

    // Count must not move across 300 clocks of pause
    task automatic frozen(input logic sl, input logic dh);
        cpuSleep <= sl;
        debugHalt <= dh;
        apb(1'b0, 12'h00C, 32'h0);
        held = rd;
        repeat (300) @(posedge clk_sys);
        rdchk("paused count", 12'h00C, held);
        cpuSleep <= 1'b0;
        debugHalt <= 1'b0;
    endtask : frozen

    initial begin
        err_total = 0;
        check_count = 0;
        cycles = 0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        lowSpeedOsc = 1'b0;
        tickSrcSelect = 1'b1;
        cpuSleep = 1'b0;
        debugHalt = 1'b0;
        @(posedge clk_sys);
        do_reset();
        rdchk("control", 12'h004, wdw_pkg::RST_WINDOW_CONTROL);
        rdchk("count", 12'h00C, 32'h0000003F);
        rdchk("flags", 12'h008, 32'h0);
        rdchk("irq enable", 12'h010, 32'h3);
        rdchk("key read", 12'h000, 32'h0);
        rdchk("unmapped", 12'h018, 32'h0);
        chk("slverr", {31'h0, se}, 32'h1);
        apb(1'b1, 12'h004, 32'h00050003);
        apb(1'b1, 12'h004, 32'h80000000);
        rdchk("locked control", 12'h004, 32'h00050003);
        apb(1'b1, 12'h000, 32'h00005AA4);
        repeat (2) @(posedge clk_sys);
        chk("wrong key", {31'h0, sysResetReq}, 32'h0);
        n = 0;
        while (matchIrq !== 1'b1 && n < 8000) begin
            @(posedge clk_sys);
            n++;
        end
        rdchk("count at match", 12'h00C, 32'h5);
        chk("irq", {31'h0, irq}, 32'h1);
        apb(1'b1, 12'h010, 32'h2);
        chk("masked irq", {31'h0, irq}, 32'h0);
        apb(1'b1, 12'h010, 32'h3);
        apb(1'b1, 12'h000, wdw_pkg::RELOAD_KEY_VALUE);
        apb(1'b0, 12'h00C, 32'h0);
        chk("no instant reload", {31'h0, rd[5:0] <= 6'h05}, 32'h1);
        apb(1'b1, 12'h008, 32'h0);
        rdchk("flag kept", 12'h008, 32'h1);
        apb(1'b1, 12'h008, 32'h1);
        rdchk("flag cleared", 12'h008, 32'h0);
        chk("match irq low", {31'h0, matchIrq}, 32'h0);
        repeat (320) @(posedge clk_sys);
        apb(1'b0, 12'h00C, 32'h0);
        chk("reloaded", {31'h0, rd[5:0] > 6'h3A}, 32'h1);
        chk("no reset", {31'h0, sysResetReq}, 32'h0);
        frozen(1'b1, 1'b0);
        frozen(1'b0, 1'b1);
        apb(1'b1, 12'h000, wdw_pkg::RELOAD_KEY_VALUE);
        repeat (2) @(posedge clk_sys);
        chk("early key", {31'h0, sysResetReq}, 32'h1);
        for (int c = 0; c < 3; c++) begin
            do_reset();
            apb(1'b1, 12'h004, 32'h00000001 | (32'(c) << 8));
            n = 0;
            while (sysResetReq !== 1'b1 && n < 20000) begin
                @(posedge clk_sys);
                n++;
            end
            chk("timeout", {31'h0, n >= 4032 * (1 << c) - 64 && n <= 4096 * (1 << c) + 64},
                32'h1);
            rdchk("timeout flag", 12'h008, 32'h2);
            chk("no match", {31'h0, matchIrq}, 32'h0);
            chk("timeout irq", {31'h0, irq}, 32'h1);
            apb(1'b1, 12'h010, 32'h1);
            chk("masked", {31'h0, irq}, 32'h0);
            apb(1'b1, 12'h010, 32'h3);
            apb(1'b1, 12'h014, 32'h2);
            rdchk("cleared", 12'h008, 32'h0);
            chk("irq off", {31'h0, irq}, 32'h0);
        end
        do_reset();
        tickSrcSelect <= 1'b0;
        apb(1'b1, 12'h004, 32'h00000001);
        repeat (2100) @(posedge clk_sys);
        rdchk("system tick count", 12'h00C, 32'h0000003E);
        test_done();
    end
endmodule : wdw_window_watchdog_test
